// >>> rtl/spi_port_pkg.sv
// Constants, types and decode helpers for the radio serial port.
// Assumes a single 40 MHz core clock; serial pins are sampled on it.
package spi_port_pkg;
   // Core clock and far-side serial clock ceilings
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SCK_WR_MAX_HZ = 16_000_000;
   localparam int unsigned SCK_RD_MAX_HZ = 9_000_000;
   // Least core cycles per half serial period, rounded up
   localparam int unsigned SCK_WR_HALF_CYC = (CLK_HZ + 2 * SCK_WR_MAX_HZ - 1) / (2 * SCK_WR_MAX_HZ);
   localparam int unsigned SCK_RD_HALF_CYC = (CLK_HZ + 2 * SCK_RD_MAX_HZ - 1) / (2 * SCK_RD_MAX_HZ);
   // Storage geometry
   localparam int unsigned REG_COUNT = 64;
   localparam int unsigned BUF_DEPTH = 128;
   localparam int unsigned BIT_LAST = 7;
   // Control word fields
   localparam int unsigned CTRL_RD_BIT = 7;
   localparam int unsigned CTRL_BUF_BIT = 6;
   // Special direct register addresses
   localparam logic [5:0] REG_GUARD = 6'h3D;
   localparam logic [5:0] REG_IND_IDX = 6'h3E;
   localparam logic [5:0] REG_IND_DATA = 6'h3F;
   localparam int unsigned GUARD_BIT = 0;
   // Reset values
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [5:0] IDX_RST = 6'h00;
   localparam logic [2:0] CNT_RST = 3'h0;

   typedef enum logic [1:0] {
      ST_CTRL = 2'b00,
      ST_INDEX = 2'b01,
      ST_DATA = 2'b11
   } port_state_t;

   function automatic logic ctrl_is_read(input logic [7:0] b);
      return b[CTRL_RD_BIT];
   endfunction

   function automatic logic ctrl_is_buf(input logic [7:0] b);
      return b[CTRL_BUF_BIT];
   endfunction
endpackage

// >>> rtl/spi_byte_if.sv
// Byte-level hand-over between the serial shifter and the access logic.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface spi_byte_if;
   logic frame_start;
   logic frame_end;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic [7:0] status;

   modport engine (
      output frame_start,
      output frame_end,
      output byte_done,
      output rx_byte,
      input tx_byte,
      input status
   );

   modport access (
      input frame_start,
      input frame_end,
      input byte_done,
      input rx_byte,
      output tx_byte,
      output status
   );
endinterface
`default_nettype wire

// >>> rtl/spi_shifter.sv
// Serial shifter: pin synchronisers, bit counting, byte framing, data out.
// Assumes mode 0 framing from the controller; data out changes after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module spi_shifter (
   // System
   input wire logic clock,
   input wire logic reset_n,
   // Pins
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   output logic miso_q,
   output logic miso_oe_q,
   // Byte side
   spi_byte_if.engine bus
);
   logic sck_m_q, sck_s_q, sck_p_q;
   logic cs_m_q, cs_s_q, cs_p_q;
   logic mosi_m_q, mosi_s_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic [2:0] cnt_q;
   logic rise;

   // Two synchroniser flops per pin, plus a third on clock and select for edges; the serial clock has no relation to ours
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {sck_m_q, sck_s_q, sck_p_q} <= 3'h0;
         {cs_m_q, cs_s_q, cs_p_q} <= 3'h7;
         {mosi_m_q, mosi_s_q} <= 2'h0;
      end
      else
      begin
         sck_m_q <= spi_sck;
         sck_s_q <= sck_m_q;
         sck_p_q <= sck_s_q;
         cs_m_q <= spi_cs_n;
         cs_s_q <= cs_m_q;
         cs_p_q <= cs_s_q;
         mosi_m_q <= spi_mosi;
         mosi_s_q <= mosi_m_q;
      end
   end

   assign rise = sck_s_q && !sck_p_q && !cs_s_q;
   assign bus.frame_start = cs_p_q && !cs_s_q;
   assign bus.frame_end = !cs_p_q && cs_s_q;
   assign bus.byte_done = rise && (cnt_q == spi_port_pkg::BIT_LAST[2:0]);
   assign bus.rx_byte = {sh_q[6:0], mosi_s_q};

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sh_q <= spi_port_pkg::BYTE_RST;
         tx_q <= spi_port_pkg::BYTE_RST;
         cnt_q <= spi_port_pkg::CNT_RST;
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end
      else if (bus.frame_start)
      begin
         cnt_q <= spi_port_pkg::CNT_RST;
         miso_q <= bus.status[7];
         tx_q <= {bus.status[6:0], 1'b0};
         miso_oe_q <= 1'b1;
      end
      else if (bus.frame_end)
      begin
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end
      else if (rise)
      begin
         sh_q <= bus.rx_byte;
         cnt_q <= cnt_q + 3'h1;
         if (bus.byte_done)
         begin
            miso_q <= bus.tx_byte[7];
            tx_q <= {bus.tx_byte[6:0], 1'b0};
         end
         else
         begin
            miso_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   property p_status_first;
      bus.frame_start |=> miso_oe_q && (miso_q == $past(bus.status[7]));
   endproperty
   a_status_first: assert property (p_status_first) else $error("status msb not first out");

   property p_release;
      bus.frame_end |=> !miso_oe_q ##1 !miso_oe_q;
   endproperty
   a_release: assert property (p_release) else $error("data out still driven after deselect");
endmodule // spi_shifter
`default_nettype wire

// >>> rtl/pkt_buffer.sv
// Shared 128-byte frame store with serial and receive write ports.
// Assumes the caller has already applied the receive overwrite guard.
`timescale 1ns/1ps
`default_nettype none
module pkt_buffer (
   // System
   input wire logic clock,
   input wire logic reset_n,
   // Serial port write
   input wire logic spi_we,
   input wire logic [6:0] spi_addr,
   input wire logic [7:0] spi_data,
   // Receive write
   input wire logic rx_we,
   input wire logic [6:0] rx_addr,
   input wire logic [7:0] rx_data,
   // Read
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem_q [spi_port_pkg::BUF_DEPTH];

   // Serial write wins a same-cycle clash; the radio frame is then stale anyway
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < spi_port_pkg::BUF_DEPTH; i++)
         begin
            mem_q[i] <= spi_port_pkg::BYTE_RST;
         end
      end
      else if (spi_we)
      begin
         mem_q[spi_addr] <= spi_data;
      end
      else if (rx_we)
      begin
         mem_q[rx_addr] <= rx_data;
      end
   end

   assign rd_data = mem_q[rd_addr];
endmodule // pkt_buffer
`default_nettype wire

// >>> rtl/radio_spi_slave_port.sv
// Slave serial port giving a controller access to registers and packet buffer.
// Assumes pins sampled on the 40 MHz core clock and a mode 0 controller.
`timescale 1ns/1ps
`default_nettype none
module radio_spi_slave_port (
   // System
   input wire logic clock,
   input wire logic reset_n,
   input wire logic hibernate,
   // Serial pins
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Core status and receive frames
   input wire logic [7:0] primary_irq_status,
   input wire logic rx_we,
   input wire logic [6:0] rx_addr,
   input wire logic [7:0] rx_data,
   // Register writes towards the core
   output logic core_wr,
   output logic core_wr_ind,
   output logic [5:0] core_wr_addr,
   output logic [7:0] core_wr_data,
   // Buffer guard state
   output logic buffer_rx_write_guard,
   output logic rx_drop
);
   spi_byte_if bus_if ();

   spi_port_pkg::port_state_t state_q;
   logic rd_q;
   logic buf_q;
   logic [6:0] addr_q;
   logic [5:0] idx_q;
   logic [7:0] dir_q [spi_port_pkg::REG_COUNT];
   logic [7:0] ind_q [spi_port_pkg::REG_COUNT];
   logic guard_q;
   logic core_wr_q;
   logic core_wr_ind_q;
   logic [5:0] core_wr_addr_q;
   logic [7:0] core_wr_data_q;
   logic rx_drop_q;
   logic miso_w;
   logic miso_oe_w;

   logic [7:0] rxb;
   logic done;
   logic in_data;
   logic is_ind;
   logic wr_reg;
   logic buf_spi_we;
   logic buf_rx_we;
   logic [6:0] addr_inc;
   logic [6:0] rd_addr;
   logic [5:0] rd_idx;
   logic rd_buf;
   logic rd_zero;
   logic [7:0] mem_rd;
   logic [7:0] tx_byte;
   localparam logic [5:0] IDX_RST_W = spi_port_pkg::IDX_RST;

   spi_shifter u_shifter (
      .clock(clock),
      .reset_n(reset_n),
      .spi_cs_n(spi_cs_n),
      .spi_sck(spi_sck),
      .spi_mosi(spi_mosi),
      .miso_q(miso_w),
      .miso_oe_q(miso_oe_w),
      .bus(bus_if)
   );

   pkt_buffer u_buffer (
      .clock(clock),
      .reset_n(reset_n),
      .spi_we(buf_spi_we),
      .spi_addr(addr_q),
      .spi_data(rxb),
      .rx_we(buf_rx_we),
      .rx_addr(rx_addr),
      .rx_data(rx_data),
      .rd_addr(rd_addr),
      .rd_data(mem_rd)
   );

   assign rxb = bus_if.rx_byte;
   assign done = bus_if.byte_done;
   assign in_data = (state_q == spi_port_pkg::ST_DATA);
   assign is_ind = !buf_q && (addr_q[5:0] == spi_port_pkg::REG_IND_DATA);
   assign wr_reg = done && in_data && !rd_q && !buf_q;
   assign buf_spi_we = done && in_data && !rd_q && buf_q;
   assign buf_rx_we = rx_we && !guard_q;
   assign bus_if.status = primary_irq_status;
   assign bus_if.tx_byte = tx_byte;

   // Buffer pointer wraps at 128, register pointer at 64
   assign addr_inc = buf_q ? addr_q + 7'h01 : {1'b0, 6'(addr_q[5:0] + 6'h01)};

   // Next byte to shift out is chosen in the cycle its predecessor completes
   always_comb
   begin
      rd_addr = addr_q;
      rd_idx = idx_q;
      rd_buf = buf_q;
      rd_zero = 1'b0;
      case (state_q)
         spi_port_pkg::ST_CTRL:
         begin
            rd_buf = spi_port_pkg::ctrl_is_buf(rxb);
            rd_addr = {1'b0, rxb[5:0]};
            rd_zero = rd_buf;
         end
         spi_port_pkg::ST_INDEX:
         begin
            rd_addr = rxb[6:0];
         end
         spi_port_pkg::ST_DATA:
         begin
            if (is_ind)
            begin
               rd_idx = idx_q + 6'h01;
            end
            else
            begin
               rd_addr = addr_inc;
            end
         end
         default:
         begin
            rd_zero = 1'b1;
         end
      endcase
   end

   always_comb
   begin
      tx_byte = spi_port_pkg::BYTE_RST;
      if (rd_zero)
      begin
         tx_byte = spi_port_pkg::BYTE_RST;
      end
      else if (rd_buf)
      begin
         tx_byte = mem_rd;
      end
      else
      begin
         case (rd_addr[5:0])
            spi_port_pkg::REG_GUARD: tx_byte = {7'h00, guard_q};
            spi_port_pkg::REG_IND_IDX: tx_byte = {2'h0, rd_idx};
            spi_port_pkg::REG_IND_DATA: tx_byte = hibernate ? spi_port_pkg::BYTE_RST : ind_q[rd_idx];
            default: tx_byte = dir_q[rd_addr[5:0]];
         endcase
      end
   end

   // Access sequencing; select edges always return to the control byte
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= spi_port_pkg::ST_CTRL;
         rd_q <= 1'b0;
         buf_q <= 1'b0;
         addr_q <= spi_port_pkg::ADDR_RST;
      end
      else if (bus_if.frame_start || bus_if.frame_end)
      begin
         state_q <= spi_port_pkg::ST_CTRL;
      end
      else if (done)
      begin
         case (state_q)
            spi_port_pkg::ST_CTRL:
            begin
               rd_q <= spi_port_pkg::ctrl_is_read(rxb);
               buf_q <= spi_port_pkg::ctrl_is_buf(rxb);
               addr_q <= {1'b0, rxb[5:0]};
               state_q <= spi_port_pkg::ctrl_is_buf(rxb) ? spi_port_pkg::ST_INDEX : spi_port_pkg::ST_DATA;
            end
            spi_port_pkg::ST_INDEX:
            begin
               addr_q <= rxb[6:0];
               state_q <= spi_port_pkg::ST_DATA;
            end
            spi_port_pkg::ST_DATA:
            begin
               if (!is_ind)
               begin
                  addr_q <= addr_inc;
               end
            end
            default:
            begin
               state_q <= spi_port_pkg::ST_CTRL;
            end
         endcase
      end
   end

   // Indirect index: set through its port, advanced by each data-port byte
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         idx_q <= spi_port_pkg::IDX_RST;
      end
      else if (done && in_data && is_ind)
      begin
         idx_q <= idx_q + 6'h01;
      end
      else if (wr_reg && addr_q[5:0] == spi_port_pkg::REG_IND_IDX)
      begin
         idx_q <= rxb[5:0];
      end
   end

   // Register store; indirect bank lives in the gated domain, so hibernate skips it
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < spi_port_pkg::REG_COUNT; i++)
         begin
            dir_q[i] <= spi_port_pkg::BYTE_RST;
            ind_q[i] <= spi_port_pkg::BYTE_RST;
         end
         guard_q <= 1'b0;
      end
      else if (wr_reg)
      begin
         case (addr_q[5:0])
            spi_port_pkg::REG_GUARD: guard_q <= rxb[spi_port_pkg::GUARD_BIT];
            spi_port_pkg::REG_IND_IDX: guard_q <= guard_q;
            spi_port_pkg::REG_IND_DATA:
            begin
               if (!hibernate)
               begin
                  ind_q[idx_q] <= rxb;
               end
            end
            default: dir_q[addr_q[5:0]] <= rxb;
         endcase
      end
   end

   // Register writes announced to the core, one cycle pulse
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         core_wr_q <= 1'b0;
         core_wr_ind_q <= 1'b0;
         core_wr_addr_q <= IDX_RST_W;
         core_wr_data_q <= spi_port_pkg::BYTE_RST;
         rx_drop_q <= 1'b0;
      end
      else
      begin
         core_wr_q <= wr_reg && !(is_ind && hibernate);
         if (wr_reg)
         begin
            core_wr_ind_q <= is_ind;
            core_wr_addr_q <= is_ind ? idx_q : addr_q[5:0];
            core_wr_data_q <= rxb;
         end
         rx_drop_q <= rx_we && guard_q;
      end
   end

   assign spi_miso = miso_w;
   assign spi_miso_oe = miso_oe_w;
   assign core_wr = core_wr_q;
   assign core_wr_ind = core_wr_ind_q;
   assign core_wr_addr = core_wr_addr_q;
   assign core_wr_data = core_wr_data_q;
   assign buffer_rx_write_guard = guard_q;
   assign rx_drop = rx_drop_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   property p_guard_blocks_rx;
      rx_we && guard_q |-> !buf_rx_we ##1 rx_drop_q;
   endproperty
   a_guard_blocks_rx: assert property (p_guard_blocks_rx) else $error("receive write passed the guard");

   property p_spi_write_unguarded;
      done && in_data && !rd_q && buf_q |=> u_buffer.mem_q[$past(addr_q)] == $past(rxb);
   endproperty
   a_spi_write_unguarded: assert property (p_spi_write_unguarded) else $error("serial buffer write dropped");

   property p_burst_advance;
      done && in_data && !is_ind && !bus_if.frame_end |=>
         addr_q == ($past(buf_q) ? 7'($past(addr_q) + 7'h01) : {1'b0, 6'($past(addr_q[5:0]) + 6'h01)});
   endproperty
   a_burst_advance: assert property (p_burst_advance) else $error("burst address did not advance");

   property p_ctrl_decode;
      done && state_q == spi_port_pkg::ST_CTRL |=>
         state_q != spi_port_pkg::ST_CTRL && rd_q == $past(rxb[7]) && buf_q == $past(rxb[6]);
   endproperty
   a_ctrl_decode: assert property (p_ctrl_decode) else $error("control byte misdecoded");

   property p_deselect_resets;
      bus_if.frame_end |=> state_q == spi_port_pkg::ST_CTRL;
   endproperty
   a_deselect_resets: assert property (p_deselect_resets) else $error("access survived deselect");

   property p_core_notify;
      wr_reg && !is_ind |=> core_wr_q && core_wr_data_q == $past(rxb);
   endproperty
   a_core_notify: assert property (p_core_notify) else $error("register write not passed to core");

   property p_hib_indirect;
      wr_reg && is_ind && hibernate |=> !core_wr_q;
   endproperty
   a_hib_indirect: assert property (p_hib_indirect) else $error("indirect write in hibernate");

   property p_ind_index_step;
      done && in_data && is_ind |=> idx_q == 6'($past(idx_q) + 6'h01);
   endproperty
   a_ind_index_step: assert property (p_ind_index_step) else $error("indirect index did not step");
endmodule // radio_spi_slave_port
`default_nettype wire

// >>> rtl/radio_spi_slave_port_fix.sv
// Intentionally empty.

// >>> bench/spi_host_model.sv
// Host controller model: sole master of select, serial clock and data in.
// Assumes the bench clock at 40 MHz; pins move on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
   parameter int HALF = 4
) (
   // System
   input wire logic clock,
   // Serial pins
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_mosi,
   input wire logic spi_miso
);
   // Clock stands low between frames
   initial
   begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic select();
      wait_clk(1);
      spi_cs_n = 1'b0;
      wait_clk(HALF);
   endtask

   // Gap covers the device's select synchroniser
   task automatic deselect();
      wait_clk(HALF);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      wait_clk(4);
   endtask

   // Half period of 4 cycles keeps the clock at 5 MHz for reads and writes
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         spi_mosi = tx[i];
         wait_clk(HALF);
         spi_sck = 1'b1;
         // Sampled one cycle after the rise, before the port can react to it
         wait_clk(1);
         rx[i] = spi_miso;
         wait_clk(HALF - 1);
         spi_sck = 1'b0;
      end
   endtask
endmodule // spi_host_model
`default_nettype wire

// >>> bench/radio_spi_slave_port_tb.sv
// Bench for the radio serial port: host model drives the pins, scenarios judge results.
// Assumes the port's hand-over timing at 40 MHz and mode 0 framing.
`timescale 1ns/1ps
`default_nettype none
module radio_spi_slave_port_tb;
   logic clock;
   logic reset_n;
   logic hibernate;
   logic spi_cs_n;
   logic spi_sck;
   logic spi_mosi;
   logic spi_miso;
   logic spi_miso_oe;
   logic [7:0] primary_irq_status;
   logic rx_we;
   logic [6:0] rx_addr;
   logic [7:0] rx_data;
   logic core_wr;
   logic core_wr_ind;
   logic [5:0] core_wr_addr;
   logic [7:0] core_wr_data;
   logic buffer_rx_write_guard;
   logic rx_drop;
   int failures = 0;
   int check_count = 0;
   int drops = 0;
   logic [14:0] wr_log [$];

   radio_spi_slave_port DUT (
      .clock(clock), .reset_n(reset_n), .hibernate(hibernate),
      .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .primary_irq_status(primary_irq_status), .rx_we(rx_we),
      .rx_addr(rx_addr), .rx_data(rx_data), .core_wr(core_wr),
      .core_wr_ind(core_wr_ind), .core_wr_addr(core_wr_addr),
      .core_wr_data(core_wr_data),
      .buffer_rx_write_guard(buffer_rx_write_guard), .rx_drop(rx_drop)
   );

   spi_host_model host (
      .clock(clock), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso)
   );

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Register write pulses last one cycle, so log them mid-cycle as they pass
   always @(negedge clock)
   begin
      if (core_wr === 1'b1)
         wr_log.push_back({core_wr_ind, core_wr_addr, core_wr_data});
      if (rx_drop === 1'b1)
         drops++;
   end

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic check_wr(input logic [14:0] exp);
      logic [14:0] got;
      check_count++;
      got = (wr_log.size() > 0) ? wr_log.pop_front() : 15'h7FFF;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t register write got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] pat(input int i);
      return 8'(i * 3 + 1);
   endfunction

   task automatic open_frame(input logic [7:0] ctrl);
      logic [7:0] st;
      host.select();
      host.xfer(ctrl, st);
      check8(st, primary_irq_status, "status byte");
   endtask

   task automatic send(input logic [7:0] b);
      logic [7:0] r;
      host.xfer(b, r);
   endtask

   task automatic get(input logic [7:0] exp);
      logic [7:0] r;
      host.xfer(8'h00, r);
      check8(r, exp, "read byte");
   endtask

   // Control writes whose core pulse is not under test
   task automatic w_reg(input logic [7:0] a, input logic [7:0] d);
      open_frame(a);
      send(d);
      host.deselect();
      wr_log.delete();
   endtask

   task automatic rx_write(input logic [6:0] a, input logic [7:0] d);
      rx_addr = a;
      rx_data = d;
      rx_we = 1'b1;
      @(negedge clock);
      rx_we = 1'b0;
      repeat (3) @(negedge clock);
   endtask

   task automatic t_reset();
      check1(spi_miso_oe, 1'b0, "oe idle");
      check1(spi_miso, 1'b0, "miso idle");
      check1(core_wr, 1'b0, "write idle");
      check1(buffer_rx_write_guard, 1'b0, "guard reset");
      $display("reset test done");
   endtask

   task automatic t_regs();
      primary_irq_status = 8'h96;
      open_frame(8'h05);
      check1(spi_miso_oe, 1'b1, "oe in frame");
      send(8'hA5);
      host.deselect();
      check1(spi_miso_oe, 1'b0, "oe after frame");
      check_wr({1'b0, 6'h05, 8'hA5});
      primary_irq_status = 8'h3C;
      open_frame(8'h10);
      for (int i = 0; i < 3; i++) send(pat(i));
      host.deselect();
      for (int i = 0; i < 3; i++) check_wr({1'b0, 6'(16 + i), pat(i)});
      open_frame(8'h90);
      for (int i = 0; i < 3; i++) get(pat(i));
      host.deselect();
      open_frame(8'h85);
      get(8'hA5);
      host.deselect();
      $display("register test done");
   endtask

   task automatic t_indirect();
      w_reg(8'h3E, 8'h02);
      open_frame(8'h3F);
      send(8'h77);
      send(8'h88);
      host.deselect();
      check_wr({1'b1, 6'h02, 8'h77});
      check_wr({1'b1, 6'h03, 8'h88});
      w_reg(8'h3E, 8'h02);
      open_frame(8'hBF);
      get(8'h77);
      get(8'h88);
      host.deselect();
      hibernate = 1'b1;
      w_reg(8'h3E, 8'h02);
      open_frame(8'hBF);
      get(8'h00);
      host.deselect();
      open_frame(8'h90);
      get(pat(0));
      host.deselect();
      hibernate = 1'b0;
      wr_log.delete();
      $display("indirect test done");
   endtask

   task automatic t_buffer();
      hibernate = 1'b1;
      open_frame(8'h40);
      send(8'h00);
      for (int i = 0; i < 128; i++) send(pat(i));
      host.deselect();
      hibernate = 1'b0;
      check8(8'(wr_log.size()), 8'h00, "no register write");
      open_frame(8'hC0);
      send(8'h00);
      for (int i = 0; i < 128; i++) get(pat(i));
      host.deselect();
      open_frame(8'hC0);
      send(8'h7F);
      get(pat(127));
      get(pat(0));
      host.deselect();
      $display("buffer test done");
   endtask

   task automatic t_guard();
      w_reg(8'h3D, 8'h01);
      check1(buffer_rx_write_guard, 1'b1, "guard set");
      rx_write(7'h07, 8'hEE);
      check8(8'(drops), 8'h01, "drop count");
      open_frame(8'h40);
      send(8'h05);
      send(8'h42);
      host.deselect();
      w_reg(8'h3D, 8'h00);
      check1(buffer_rx_write_guard, 1'b0, "guard clear");
      rx_write(7'h06, 8'hC3);
      check8(8'(drops), 8'h01, "drop count");
      open_frame(8'hC0);
      send(8'h05);
      get(8'h42);
      get(8'hC3);
      get(pat(7));
      host.deselect();
      $display("guard test done");
   endtask

   // Watchdog against a stalled sequence
   initial
   begin
      repeat (60000) @(posedge clock);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   initial
   begin
      reset_n = 1'b0;
      hibernate = 1'b0;
      primary_irq_status = 8'h00;
      rx_we = 1'b0;
      rx_addr = 7'h00;
      rx_data = 8'h00;
      repeat (8) @(negedge clock);
      reset_n = 1'b1;
      repeat (4) @(negedge clock);
      t_reset();
      t_regs();
      t_indirect();
      t_buffer();
      t_guard();
      wrap_up();
   end
endmodule // radio_spi_slave_port_tb
`default_nettype wire
